// ===== tpo_pkg.sv
// Package with register map, field positions, reset values and timing counts of the timer block.
package tpo_pkg;

   // Register indices; byte address is four times the index.
   localparam logic [7:0] TPO_IDX_TIMER_COUNT    = 8'h01;
   localparam logic [7:0] TPO_IDX_INT_CONTROL    = 8'h0b;
   localparam logic [7:0] TPO_IDX_OPTION_CONTROL = 8'h81;
   localparam logic [7:0] TPO_IDX_PIN_DIRECTION  = 8'h85;
   localparam logic [7:0] TPO_IDX_IRQ_STATUS     = 8'h90;
   localparam logic [7:0] TPO_IDX_IRQ_MASK       = 8'h91;

   // Option control fields.
   localparam int TPO_OPT_CLOCK_SOURCE_POS = 5;
   localparam int TPO_OPT_SOURCE_EDGE_POS  = 4;
   localparam int TPO_OPT_ASSIGN_POS       = 3;
   localparam int TPO_OPT_RATE_LSB         = 0;
   localparam int TPO_RATE_W               = 3;

   // Interrupt control fields.
   localparam int TPO_INT_OVF_ENABLE_POS = 5;
   localparam int TPO_INT_OVF_FLAG_POS   = 2;

   // Interrupt status and mask fields.
   localparam int TPO_IRQ_W            = 2;
   localparam int TPO_IRQ_OVERFLOW_POS = 0;
   localparam int TPO_IRQ_WDT_POST_POS = 1;

   // Reset values.
   localparam logic [7:0] TPO_RST_TIMER_COUNT    = 8'h00;
   localparam logic [7:0] TPO_RST_INT_CONTROL    = 8'h00;
   localparam logic [7:0] TPO_RST_OPTION_CONTROL = 8'hff;
   localparam logic [7:0] TPO_RST_PIN_DIRECTION  = 8'h3f;
   localparam logic [7:0] TPO_PIN_DIRECTION_MASK = 8'h3f;
   localparam logic [TPO_IRQ_W-1:0] TPO_RST_IRQ  = 2'h0;

   // Timing: 125 MHz core clock, instruction cycle of four clocks.
   localparam int          TPO_CLK_MHZ        = 125;
   localparam int          TPO_INSTR_CLOCKS   = 4;
   localparam logic [1:0]  TPO_INSTR_DIV_LAST = 2'(TPO_INSTR_CLOCKS - 1);
   localparam int          TPO_WRITE_INHIBIT_CYCLES = 2;
   localparam logic [1:0]  TPO_WRITE_INHIBIT  = 2'(TPO_WRITE_INHIBIT_CYCLES);

   localparam int TPO_PRESCALE_W = 8;

endpackage

// ===== tpo_prescaler.sv
// Shared 8-bit prescaler counter with ratio select for timer or watchdog use.
`timescale 1ns/1ps
module tpo_prescaler import tpo_pkg::*; (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   // Control
   input  wire logic                  i_to_watchdog,
   input  wire logic [TPO_RATE_W-1:0] i_rate,
   input  wire logic                  i_clear,
   input  wire logic                  i_tick,
   // Divided event, combinational from the count
   output logic                       o_event
);

   typedef struct packed {
      logic [TPO_PRESCALE_W-1:0] count;
   } tpo_pre_state_t;

   tpo_pre_state_t state;
   tpo_pre_state_t next_state;
   logic [TPO_PRESCALE_W-1:0] low_mask;
   logic [3:0]                width;

   // Timer ratio is 2^(rate+1), watchdog ratio is 2^rate.
   always_comb begin
      width    = {1'b0, i_rate} + {3'h0, ~i_to_watchdog};
      low_mask = TPO_PRESCALE_W'((9'h001 << width) - 9'h001);
      o_event  = i_tick && ((state.count & low_mask) == low_mask);
      next_state = state;
      if (i_clear) begin
         next_state.count = '0;
      end else if (i_tick) begin
         next_state.count = state.count + 8'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

endmodule // tpo_prescaler

// ===== tpo_timer.sv
// Timer counter with shared prescaler, option control and an Avalon-MM register slave.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tpo_timer import tpo_pkg::*; (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // Avalon-MM slave
   input  wire logic [9:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [3:0]  i_byteenable,
   input  wire logic [31:0] i_writedata,
   output logic [31:0]      o_readdata,
   output logic             o_waitrequest,
   // Watchdog side
   input  wire logic        i_wdt_tick,
   input  wire logic        i_wdt_clear,
   output logic             o_wdt_post,
   // Pins and status
   input  wire logic        i_timer_external_clock_pin,
   output logic [7:0]       o_pin_direction,
   output logic             o_irq
);

   typedef struct packed {
      logic [1:0]           instr_div;
      logic                 pin_meta;
      logic                 pin_sync;
      logic                 pin_prev;
      logic [7:0]           timer_count;
      logic [1:0]           inhibit;
      logic [7:0]           int_control;
      logic [7:0]           option_control;
      logic [7:0]           pin_direction;
      logic [TPO_IRQ_W-1:0] irq_status;
      logic [TPO_IRQ_W-1:0] irq_mask;
      logic                 waitrequest;
      logic [31:0]          readdata;
      logic                 irq;
      logic                 wdt_post;
   } tpo_state_t;

   tpo_state_t state;
   tpo_state_t next_state;

   logic       instr_tick;
   logic       pin_edge;
   logic       src_event;
   logic       to_watchdog;
   logic       pre_tick;
   logic       pre_clear;
   logic       pre_event;
   logic       timer_inc;
   logic       overflow;
   logic       access;
   logic       do_write;
   logic       do_read;
   logic [7:0] index;
   logic [7:0] wdata;

   // Read value of a register index; the prescaler count is never visible.
   function automatic logic [7:0] reg_value(input tpo_state_t s, input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         TPO_IDX_TIMER_COUNT:    v = s.timer_count;
         TPO_IDX_INT_CONTROL:    v = s.int_control;
         TPO_IDX_OPTION_CONTROL: v = s.option_control;
         TPO_IDX_PIN_DIRECTION:  v = s.pin_direction;
         TPO_IDX_IRQ_STATUS:     v = {6'h00, s.irq_status};
         TPO_IDX_IRQ_MASK:       v = {6'h00, s.irq_mask};
         default:                v = 8'h00;
      endcase
      return v;
   endfunction

   // Write hit on a register index in the low byte lane.
   function automatic logic hit(input logic wr, input logic [7:0] idx, input logic [7:0] want);
      return wr && (idx == want);
   endfunction

   assign index    = i_address[9:2];
   assign wdata    = i_writedata[7:0];
   assign access   = i_read || i_write;
   assign do_write = i_write && !state.waitrequest && i_byteenable[0];
   assign do_read  = i_read && !state.waitrequest;

   assign instr_tick  = (state.instr_div == TPO_INSTR_DIV_LAST);
   assign to_watchdog = state.option_control[TPO_OPT_ASSIGN_POS];

   // Pin edge selection compares the second synchroniser stage with its one-clock delayed copy.
   always_comb begin
      if (state.option_control[TPO_OPT_SOURCE_EDGE_POS]) begin
         pin_edge = state.pin_prev && !state.pin_sync;
      end else begin
         pin_edge = !state.pin_prev && state.pin_sync;
      end
   end

   // Source event, held off while the post-write inhibit runs.
   always_comb begin
      if (state.option_control[TPO_OPT_CLOCK_SOURCE_POS]) begin
         src_event = pin_edge;
      end else begin
         src_event = instr_tick;
      end
      if (state.inhibit != 2'h0) begin
         src_event = 1'b0;
      end
   end

   // One prescaler, fed by whichever side owns it.
   assign pre_tick  = to_watchdog ? i_wdt_tick : src_event;
   assign pre_clear = to_watchdog ? i_wdt_clear
                                  : hit(do_write, index, TPO_IDX_TIMER_COUNT);
   assign timer_inc = to_watchdog ? src_event : pre_event;
   assign overflow  = timer_inc && (state.timer_count == 8'hff);

   tpo_prescaler u_prescaler (
      .i_clk         (i_clk),
      .i_rst_n       (i_rst_n),
      .i_to_watchdog (to_watchdog),
      .i_rate        (state.option_control[TPO_OPT_RATE_LSB +: TPO_RATE_W]),
      .i_clear       (pre_clear),
      .i_tick        (pre_tick),
      .o_event       (pre_event)
   );

   always_comb begin
      next_state = state;

      next_state.instr_div = instr_tick ? 2'h0 : state.instr_div + 2'h1;
      next_state.pin_meta  = i_timer_external_clock_pin;
      next_state.pin_sync  = state.pin_meta;
      next_state.pin_prev  = state.pin_sync;

      // One wait state: request seen, then answered with waitrequest low.
      next_state.waitrequest = !(access && state.waitrequest);
      if (access && state.waitrequest) begin
         next_state.readdata = {24'h000000, reg_value(state, index)};
      end

      // Timer count and inhibit; a software write wins over counting.
      if (instr_tick && (state.inhibit != 2'h0)) begin
         next_state.inhibit = state.inhibit - 2'h1;
      end
      if (timer_inc) begin
         next_state.timer_count = state.timer_count + 8'h01;
      end
      if (hit(do_write, index, TPO_IDX_TIMER_COUNT)) begin
         next_state.timer_count = wdata;
         next_state.inhibit     = TPO_WRITE_INHIBIT;
      end

      if (hit(do_write, index, TPO_IDX_INT_CONTROL)) begin
         next_state.int_control = wdata;
      end
      if (overflow) begin
         next_state.int_control[TPO_INT_OVF_FLAG_POS] = 1'b1;
      end

      if (hit(do_write, index, TPO_IDX_OPTION_CONTROL)) begin
         next_state.option_control = wdata;
      end
      if (hit(do_write, index, TPO_IDX_PIN_DIRECTION)) begin
         next_state.pin_direction = wdata & TPO_PIN_DIRECTION_MASK;
      end
      if (hit(do_write, index, TPO_IDX_IRQ_MASK)) begin
         next_state.irq_mask = wdata[TPO_IRQ_W-1:0];
      end

      // Sticky status: read clears, a new event in the same cycle survives.
      if (do_read && (index == TPO_IDX_IRQ_STATUS)) begin
         next_state.irq_status = '0;
      end
      if (overflow) begin
         next_state.irq_status[TPO_IRQ_OVERFLOW_POS] = 1'b1;
      end
      if (to_watchdog && pre_event) begin
         next_state.irq_status[TPO_IRQ_WDT_POST_POS] = 1'b1;
      end

      next_state.wdt_post = to_watchdog && pre_event;
      next_state.irq      = |(next_state.irq_status & state.irq_mask);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state                <= '0;
         state.timer_count    <= TPO_RST_TIMER_COUNT;
         state.int_control    <= TPO_RST_INT_CONTROL;
         state.option_control <= TPO_RST_OPTION_CONTROL;
         state.pin_direction  <= TPO_RST_PIN_DIRECTION;
         state.irq_status     <= TPO_RST_IRQ;
         state.irq_mask       <= TPO_RST_IRQ;
         state.waitrequest    <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign o_readdata      = state.readdata;
   assign o_waitrequest   = state.waitrequest;
   assign o_wdt_post      = state.wdt_post;
   assign o_pin_direction = state.pin_direction;
   assign o_irq           = state.irq;

endmodule // tpo_timer

// ===== tpo_timer_checker.sv
// Checker of the timer block's port behaviour.
`timescale 1ns/1ps
module tpo_timer_checker import tpo_pkg::*; (
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   // Bus and watchdog inputs
   input wire logic [9:0]  i_address,
   input wire logic        i_read,
   input wire logic        i_write,
   input wire logic [31:0] i_writedata,
   input wire logic        i_wdt_tick,
   // Observed outputs
   input wire logic [31:0] o_readdata,
   input wire logic        o_waitrequest,
   input wire logic        o_wdt_post,
   input wire logic [7:0]  o_pin_direction
);
   logic [7:0] opt;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Copy of the option register, taken from accepted writes.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         opt <= TPO_RST_OPTION_CONTROL;
      end else if (i_write && !o_waitrequest && i_address[9:2] == TPO_IDX_OPTION_CONTROL) begin
         opt <= i_writedata[7:0];
      end
   end
   a_idle_wait: assert property (!$past(i_read) && !$past(i_write) |-> o_waitrequest)
      else $error("answer without request");
   a_one_wait: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("no answer after one wait");
   a_short_answer: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("answer held too long");
   a_upper_zero: assert property (!o_waitrequest |-> o_readdata[31:8] == 24'h0)
      else $error("read data above bit 7");
   a_dir_reset: assert property (!$past(i_rst_n) |-> o_pin_direction == TPO_RST_PIN_DIRECTION)
      else $error("pin direction reset value");
   a_dir_top: assert property (o_pin_direction[7:6] == 2'h0)
      else $error("pin direction top bits set");
   a_post_tick: assert property (o_wdt_post |-> $past(i_wdt_tick))
      else $error("post without tick");
   a_post_rate0: assert property (opt[3] && opt[2:0] == 3'h0 && i_wdt_tick |=> o_wdt_post)
      else $error("no post at ratio one");
   c_post: cover property (o_wdt_post);
   c_write: cover property (i_write && !o_waitrequest);
   c_read: cover property (i_read && !o_waitrequest);
endmodule // tpo_timer_checker

bind tpo_timer tpo_timer_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
   .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_wdt_tick(i_wdt_tick),
   .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_wdt_post(o_wdt_post),
   .o_pin_direction(o_pin_direction));

// ===== tpo_core_model.sv
// Core model: bus master of the timer block and source of watchdog clears.
`timescale 1ns/1ps
module tpo_core_model import tpo_pkg::*; (
   // Clock and bus answer
   input  wire logic        i_clk,
   input  wire logic [31:0] i_readdata,
   input  wire logic        i_waitrequest,
   // Bus request
   output logic [9:0]       o_address,
   output logic             o_read,
   output logic             o_write,
   output logic [3:0]       o_byteenable,
   output logic [31:0]      o_writedata,
   // Watchdog clear and bus timeout
   output logic             o_wdt_clear,
   output logic             o_hung
);
   initial begin
      o_address = 10'h0;
      o_read = 1'b0;
      o_write = 1'b0;
      o_byteenable = 4'hf;
      o_writedata = 32'h0;
      o_wdt_clear = 1'b0;
      o_hung = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge i_clk);
      o_address <= {idx, 2'h0};
      o_writedata <= {24'h0, d};
      o_write <= w;
      o_read <= ~w;
      do begin
         @(posedge i_clk);
         n++;
      end while (i_waitrequest !== 1'b0 && n < 64);
      q = i_readdata[7:0];
      if (i_waitrequest !== 1'b0) o_hung <= 1'b1;
      o_write <= 1'b0;
      o_read <= 1'b0;
      // Released data does not keep its last value.
      o_writedata <= ~o_writedata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, idx, d, q);
   endtask
   task automatic clrwdt();
      @(posedge i_clk);
      o_wdt_clear <= 1'b1;
      @(posedge i_clk);
      o_wdt_clear <= 1'b0;
   endtask
   task automatic to_wdt(input logic [2:0] rate);
      clrwdt();
      wr(TPO_IDX_TIMER_COUNT, 8'h0);
      if (rate < 3'h2) begin
         wr(TPO_IDX_OPTION_CONTROL, 8'h2f);
         clrwdt();
      end
      wr(TPO_IDX_OPTION_CONTROL, {5'h05, rate});
   endtask
   task automatic to_timer();
      clrwdt();
      wr(TPO_IDX_OPTION_CONTROL, 8'h00);
   endtask
endmodule // tpo_core_model

// ===== tpo_timer_bench.sv
// Self-checking bench of the timer block.
`timescale 1ns/1ps
module tpo_timer_bench import tpo_pkg::*;;
   logic        clk, rst_n, read, write, waitreq, tick, clear, post, pin, irq, hung;
   logic [9:0]  address;
   logic [3:0]  be;
   logic [31:0] wdata, rdata;
   logic [7:0]  dir;
   int          n_fail = 0, samples_checked = 0, n_post = 0;
   tpo_timer dut (.i_clk(clk), .i_rst_n(rst_n), .i_address(address), .i_read(read), .i_write(write),
      .i_byteenable(be), .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq),
      .i_wdt_tick(tick), .i_wdt_clear(clear), .o_wdt_post(post), .i_timer_external_clock_pin(pin),
      .o_pin_direction(dir), .o_irq(irq));
   tpo_core_model core (.i_clk(clk), .i_readdata(rdata), .i_waitrequest(waitreq), .o_address(address),
      .o_read(read), .o_write(write), .o_byteenable(be), .o_writedata(wdata), .o_wdt_clear(clear),
      .o_hung(hung));
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      core.xfer(1'b0, idx, 8'h0, q);
      chk(q, exp);
   endtask
   task automatic tick_n(input int n);
      repeat (n) begin
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic s_regs();
      rdchk(TPO_IDX_OPTION_CONTROL, 8'hff);
      rdchk(TPO_IDX_TIMER_COUNT, 8'h00);
      rdchk(TPO_IDX_INT_CONTROL, 8'h00);
      rdchk(TPO_IDX_IRQ_STATUS, 8'h00);
      core.wr(TPO_IDX_PIN_DIRECTION, 8'h55);
      rdchk(TPO_IDX_PIN_DIRECTION, 8'h15);
      chk(dir, 8'h15);
      core.wr(8'h40, 8'h5a);
      rdchk(8'h40, 8'h00);
   endtask
   task automatic s_timer();
      int ratio;
      for (int r = 0; r < 8; r++) begin
         ratio = 2 << r;
         core.wr(TPO_IDX_OPTION_CONTROL, 8'(r));
         core.wr(TPO_IDX_TIMER_COUNT, 8'h0);
         repeat (4 * (2 * ratio + 2)) @(posedge clk);
         rdchk(TPO_IDX_TIMER_COUNT, 8'h02);
      end
   endtask
   task automatic s_irq();
      core.wr(TPO_IDX_OPTION_CONTROL, 8'h08);
      core.wr(TPO_IDX_TIMER_COUNT, 8'hfd);
      // Exactly one instruction tick falls before the sample, and it is suppressed.
      repeat (3) @(posedge clk);
      rdchk(TPO_IDX_TIMER_COUNT, 8'hfd);
      repeat (40) @(posedge clk);
      chk(irq, 1'b0);
      rdchk(TPO_IDX_INT_CONTROL, 8'h04);
      core.wr(TPO_IDX_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      rdchk(TPO_IDX_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      core.wr(TPO_IDX_INT_CONTROL, 8'h00);
      rdchk(TPO_IDX_INT_CONTROL, 8'h00);
   endtask
   task automatic s_pin();
      for (int e = 0; e < 2; e++) begin
         core.wr(TPO_IDX_OPTION_CONTROL, 8'h28 | 8'(e << 4));
         core.wr(TPO_IDX_TIMER_COUNT, 8'h0);
         repeat (12) @(posedge clk);
         repeat (5) begin
            pin <= 1'b1;
            repeat (4) @(posedge clk);
            pin <= 1'b0;
            repeat (4) @(posedge clk);
         end
         pin <= 1'b1;
         repeat (8) @(posedge clk);
         rdchk(TPO_IDX_TIMER_COUNT, 8'(6 - e));
         pin <= 1'b0;
      end
   endtask
   task automatic s_wdt();
      for (int r = 0; r < 8; r++) begin
         core.to_wdt(3'(r));
         tick_n((1 << r) - 1);
         core.clrwdt();
         n_post = 0;
         tick_n((2 << r) - 1);
         chk(n_post, 1);
      end
      core.to_timer();
      rdchk(TPO_IDX_OPTION_CONTROL, 8'h00);
   endtask
   always @(posedge clk) if (post === 1'b1) n_post++;
   always @(posedge hung) begin
      n_fail++;
      end_of_test();
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      tick = 1'b0;
      pin = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      s_regs();
      s_timer();
      s_irq();
      s_pin();
      s_wdt();
      end_of_test();
   end
endmodule // tpo_timer_bench
